//--- ucp_phy_end.sv
// PHY end of the UTOPIA multi-PHY cell port
// What this block does
// - Transmit bus is 16 or 8 bits
// - Discard transmit words between cells
// - Sample transmit parity, odd or even sense
// - Master sends start marker plus 26/52 more
// - After a cell, wait for marker with enable
// - Capture transmit data on transmit clock rise
// - Master keeps transmit clock under limits
// - Master enables transmit only for valid data
// - Drive tri-stateable transmit cell-available flag
// - Master drives five-bit transmit PHY address
// - Drive receive bus only when enabled, selected
// - Generate receive parity, odd or even sense
// - Receive start marker flags first word
// - Receive outputs change after receive clock rise
// - Enable now means sampled next cycle end
// - Drive receive bus only after enabled cycle
// - Master never ties receive enable low
// - Drive tri-stateable receive cell-available flag
// - Master drives five-bit receive PHY address
`timescale 1ns/10ps
`include "ucp_regs.svh"
module ucp_phy_end #(
	parameter int CELL_WORDS = `UCP_CELL_BYTES
)(
	ucp_link_if.phy link,
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic bus16_i,
	input wire logic odd_par_i,
	input wire logic [4:0] port_addr_i,
	input wire logic tx_sink_ready_i,
	output logic [15:0] tx_word_o,
	output logic tx_first_o,
	output logic tx_par_err_o,
	output logic tx_valid_o,
	input wire logic [15:0] rx_word_i,
	input wire logic rx_valid_i,
	output logic rx_ready_o
);
	logic [15:0] cell_mem [0:CELL_WORDS-1];
	logic [7:0] cfg_w;
	assign cfg_w = {tx_sink_ready_i, bus16_i, odd_par_i, port_addr_i};

	// Transmit link domain: reset and settings brought over
	logic txr_meta_r;
	logic txr_rst_r;
	logic tx_up_r;
	logic [7:0] txc_meta_r;
	logic [7:0] txc_r;
	always_ff @(posedge link.tx_cell_clock)
	begin
		txr_meta_r <= rst_i;
		txr_rst_r <= txr_meta_r;
		tx_up_r <= !txr_rst_r;
		txc_meta_r <= cfg_w;
		txc_r <= txc_meta_r;
	end

	logic tx_b16;
	logic [5:0] tx_last;
	assign tx_b16 = txc_r[6];
	assign tx_last = tx_b16 ? `UCP_LAST16 : `UCP_LAST8;

	// Cell-available only while polled on our address
	// No space shown before the link side has left reset and while the sink is not ready
	assign link.tx_cell_space_available_o = txc_r[7] && tx_up_r;
	assign link.tx_cell_space_available_oe = link.tx_phy_select == txc_r[4:0];

	logic tx_sel_r;
	always_ff @(posedge link.tx_cell_clock)
	begin
		if (txr_rst_r)
			tx_sel_r <= 1'b0;
		else if (link.tx_cell_enable_n)
			tx_sel_r <= link.tx_phy_select == txc_r[4:0];
	end

	ucp_pkg::ucp_cell_st_t tx_st_r;
	logic [5:0] tx_cnt_r;
	logic tx_take_w;
	// Outside a cell only a start marker opens one
	assign tx_take_w = !link.tx_cell_enable_n && tx_sel_r &&
		(tx_st_r == ucp_pkg::UCP_CELL || link.tx_cell_start_marker);

	always_ff @(posedge link.tx_cell_clock)
	begin
		if (txr_rst_r)
		begin
			tx_st_r <= ucp_pkg::UCP_IDLE;
			tx_cnt_r <= 6'h00;
		end
		else if (tx_take_w)
		begin
			if (link.tx_cell_start_marker)
			begin
				tx_st_r <= ucp_pkg::UCP_CELL;
				tx_cnt_r <= 6'h01;
			end
			else if (tx_cnt_r == tx_last)
			begin
				tx_st_r <= ucp_pkg::UCP_IDLE;
				tx_cnt_r <= 6'h00;
			end
			else
				tx_cnt_r <= tx_cnt_r + 6'h01;
		end
	end

	logic [15:0] tx_data_r;
	logic tx_first_r;
	logic tx_perr_r;
	logic tx_tog_r;
	always_ff @(posedge link.tx_cell_clock)
	begin
		if (txr_rst_r)
		begin
			tx_data_r <= `UCP_WORD_RST;
			tx_first_r <= 1'b0;
			tx_perr_r <= 1'b0;
			tx_tog_r <= 1'b0;
		end
		else if (tx_take_w)
		begin
			tx_data_r <= ucp_pkg::ucp_mask(link.tx_cell_word_bus, tx_b16);
			tx_first_r <= link.tx_cell_start_marker;
			tx_perr_r <= link.tx_cell_parity_bit !=
				ucp_pkg::ucp_par(link.tx_cell_word_bus, tx_b16, txc_r[5]);
			tx_tog_r <= ~tx_tog_r;
		end
	end

	// System domain: each captured word arrives by toggle
	logic txt_meta_r;
	logic txt_s_r;
	logic txt_d_r;
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			txt_meta_r <= 1'b0;
			txt_s_r <= 1'b0;
			txt_d_r <= 1'b0;
		end
		else
		begin
			txt_meta_r <= tx_tog_r;
			txt_s_r <= txt_meta_r;
			txt_d_r <= txt_s_r;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			tx_word_o <= `UCP_WORD_RST;
			tx_first_o <= 1'b0;
			tx_par_err_o <= 1'b0;
			tx_valid_o <= 1'b0;
		end
		else
		begin
			tx_valid_o <= txt_s_r ^ txt_d_r;
			if (txt_s_r ^ txt_d_r)
			begin
				tx_word_o <= tx_data_r;
				tx_first_o <= tx_first_r;
				tx_par_err_o <= tx_perr_r;
			end
		end
	end

	// System domain: cell loading for the receive direction
	logic full_r;
	logic [5:0] wr_r;
	logic rxd_meta_r;
	logic rxd_s_r;
	logic rxd_d_r;
	logic rx_done_tog_r;
	logic [5:0] sys_last;
	assign sys_last = bus16_i ? `UCP_LAST16 : `UCP_LAST8;
	assign rx_ready_o = !full_r;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			rxd_meta_r <= 1'b0;
			rxd_s_r <= 1'b0;
			rxd_d_r <= 1'b0;
		end
		else
		begin
			rxd_meta_r <= rx_done_tog_r;
			rxd_s_r <= rxd_meta_r;
			rxd_d_r <= rxd_s_r;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rx_valid_i && !full_r)
			cell_mem[wr_r] <= rx_word_i;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			full_r <= 1'b0;
			wr_r <= 6'h00;
		end
		else if (rx_valid_i && !full_r)
		begin
			full_r <= wr_r == sys_last;
			wr_r <= (wr_r == sys_last) ? 6'h00 : wr_r + 6'h01;
		end
		else if (rxd_s_r ^ rxd_d_r)
			full_r <= 1'b0;
	end

	// Receive link domain
	logic rxr_meta_r;
	logic rxr_rst_r;
	logic [7:0] rxc_meta_r;
	logic [7:0] rxc_r;
	always_ff @(posedge link.rx_cell_clock)
	begin
		rxr_meta_r <= rst_i;
		rxr_rst_r <= rxr_meta_r;
		rxc_meta_r <= {full_r, cfg_w[6:0]};
		rxc_r <= rxc_meta_r;
	end

	logic rx_b16;
	logic [5:0] rx_last;
	logic rx_sel_r;
	logic sent_r;
	logic rx_avail_w;
	logic rx_go_w;
	logic [5:0] rd_r;
	logic [15:0] rx_word_w;
	assign rx_b16 = rxc_r[6];
	assign rx_last = rx_b16 ? `UCP_LAST16 : `UCP_LAST8;
	assign rx_avail_w = rxc_r[7] && !sent_r;
	assign rx_go_w = !link.rx_cell_enable_n && rx_sel_r && rx_avail_w;
	assign rx_word_w = cell_mem[rd_r];

	assign link.rx_cell_ready_available_o = rx_avail_w;
	assign link.rx_cell_ready_available_oe = link.rx_phy_select == rxc_r[4:0];

	always_ff @(posedge link.rx_cell_clock)
	begin
		if (rxr_rst_r)
			rx_sel_r <= 1'b0;
		else if (link.rx_cell_enable_n)
			rx_sel_r <= link.rx_phy_select == rxc_r[4:0];
	end

	// Drivers on only in the cycle after an enabled, selected one
	always_ff @(posedge link.rx_cell_clock)
	begin
		if (rxr_rst_r)
			link.rx_cell_bus_oe <= 1'b0;
		else
			link.rx_cell_bus_oe <= !link.rx_cell_enable_n && rx_sel_r;
	end

	always_ff @(posedge link.rx_cell_clock)
	begin
		if (rxr_rst_r)
		begin
			rd_r <= 6'h00;
			sent_r <= 1'b0;
			rx_done_tog_r <= 1'b0;
		end
		else if (rx_go_w)
		begin
			rd_r <= (rd_r == rx_last) ? 6'h00 : rd_r + 6'h01;
			if (rd_r == rx_last)
			begin
				sent_r <= 1'b1;
				rx_done_tog_r <= ~rx_done_tog_r;
			end
		end
		else if (!rxc_r[7])
			sent_r <= 1'b0;
	end

	// Outputs move only on the receive clock rise
	always_ff @(posedge link.rx_cell_clock)
	begin
		if (rxr_rst_r)
		begin
			link.rx_cell_word_bus_o <= `UCP_WORD_RST;
			link.rx_cell_parity_bit_o <= 1'b0;
			link.rx_cell_start_marker_o <= 1'b0;
		end
		else
		begin
			link.rx_cell_start_marker_o <= rx_go_w && rd_r == 6'h00;
			if (rx_go_w)
			begin
				link.rx_cell_word_bus_o <= ucp_pkg::ucp_mask(rx_word_w, rx_b16);
				link.rx_cell_parity_bit_o <= ucp_pkg::ucp_par(rx_word_w, rx_b16, rxc_r[5]);
			end
		end
	end
endmodule

//--- ucp_regs.svh
// Constants for the UTOPIA cell port
`ifndef UCP_REGS_SVH
`define UCP_REGS_SVH
`define UCP_LAST16 6'h1A
`define UCP_LAST8 6'h34
`define UCP_CELL_BYTES 53
`define UCP_LINK_DIV 5
`define UCP_WORD_RST 16'h0000
`define UCP_ADDR_RST 5'h1F
`endif

//--- ucp_pkg.sv
// Types and helpers shared by both cell port ends
package ucp_pkg;
	typedef enum logic [1:0] {
		UCP_IDLE = 2'b01,
		UCP_CELL = 2'b10
	} ucp_cell_st_t;

	// Parity bit over the active width
	function automatic logic ucp_par(input logic [15:0] d, input logic b16, input logic odd);
		logic [15:0] m;
		m = b16 ? d : {8'h00, d[7:0]};
		return (^m) ^ odd;
	endfunction

	function automatic logic [15:0] ucp_mask(input logic [15:0] d, input logic b16);
		return b16 ? d : {8'h00, d[7:0]};
	endfunction
endpackage

//--- ucp_link_if.sv
// Link wires between the ATM layer end and the PHY end
`timescale 1ns/10ps
interface ucp_link_if;
	logic tx_cell_clock;
	logic [15:0] tx_cell_word_bus;
	logic tx_cell_parity_bit;
	logic tx_cell_start_marker;
	logic tx_cell_enable_n;
	logic [4:0] tx_phy_select;
	logic tx_cell_space_available_o;
	logic tx_cell_space_available_oe;
	logic tx_cell_space_available;
	logic rx_cell_clock;
	logic rx_cell_enable_n;
	logic [4:0] rx_phy_select;
	logic [15:0] rx_cell_word_bus_o;
	logic rx_cell_parity_bit_o;
	logic rx_cell_start_marker_o;
	logic rx_cell_bus_oe;
	logic rx_cell_ready_available_o;
	logic rx_cell_ready_available_oe;
	logic [15:0] rx_cell_word_bus;
	logic rx_cell_parity_bit;
	logic rx_cell_start_marker;
	logic rx_cell_ready_available;

	// Undriven wires settle low, as a pull-down would hold them
	assign tx_cell_space_available = tx_cell_space_available_oe & tx_cell_space_available_o;
	assign rx_cell_word_bus = rx_cell_bus_oe ? rx_cell_word_bus_o : 16'h0000;
	assign rx_cell_parity_bit = rx_cell_bus_oe & rx_cell_parity_bit_o;
	assign rx_cell_start_marker = rx_cell_bus_oe & rx_cell_start_marker_o;
	assign rx_cell_ready_available = rx_cell_ready_available_oe & rx_cell_ready_available_o;

	modport phy (
		input tx_cell_clock, tx_cell_word_bus, tx_cell_parity_bit, tx_cell_start_marker,
		input tx_cell_enable_n, tx_phy_select, rx_cell_clock, rx_cell_enable_n, rx_phy_select,
		output tx_cell_space_available_o, tx_cell_space_available_oe,
		output rx_cell_word_bus_o, rx_cell_parity_bit_o, rx_cell_start_marker_o,
		output rx_cell_bus_oe, rx_cell_ready_available_o, rx_cell_ready_available_oe
	);
	modport atm (
		output tx_cell_clock, tx_cell_word_bus, tx_cell_parity_bit, tx_cell_start_marker,
		output tx_cell_enable_n, tx_phy_select, rx_cell_clock, rx_cell_enable_n, rx_phy_select,
		input tx_cell_space_available, rx_cell_word_bus, rx_cell_parity_bit,
		input rx_cell_start_marker, rx_cell_ready_available
	);
endinterface

//--- ucp_atm_end.sv
// ATM layer end of the UTOPIA multi-PHY cell port
`timescale 1ns/10ps
`include "ucp_regs.svh"
module ucp_atm_end #(
	parameter int LINK_DIV = `UCP_LINK_DIV
)(
	ucp_link_if.atm link,
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic bus16_i,
	input wire logic odd_par_i,
	input wire logic [4:0] tgt_addr_i,
	input wire logic [15:0] tx_word_i,
	input wire logic tx_first_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic rx_accept_i,
	output logic [15:0] rx_word_o,
	output logic rx_first_o,
	output logic rx_par_err_o,
	output logic rx_valid_o
);
	localparam logic [7:0] DIV_LAST = 8'(LINK_DIV - 1);
	localparam logic [7:0] DIV_FALL = 8'(LINK_DIV / 2 - 1);

	logic [7:0] cnt_r;
	// Known start level, so the link clock toggles during reset
	logic lclk_r = 1'b0;
	logic tick_w;
	logic [5:0] last_w;
	assign tick_w = cnt_r == DIV_FALL;
	assign last_w = bus16_i ? `UCP_LAST16 : `UCP_LAST8;
	// Both link clocks come from one divider; they also run in reset
	assign link.tx_cell_clock = lclk_r;
	assign link.rx_cell_clock = lclk_r;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			cnt_r <= 8'h00;
			lclk_r <= ~lclk_r;
		end
		else
		begin
			cnt_r <= (cnt_r == DIV_LAST) ? 8'h00 : cnt_r + 8'h01;
			if (cnt_r == DIV_LAST)
				lclk_r <= 1'b1;
			else if (tick_w)
				lclk_r <= 1'b0;
		end
	end

	// Transmit: poll, then send a whole cell
	ucp_pkg::ucp_cell_st_t tx_st_r;
	logic [5:0] tx_cnt_r;
	logic tx_start_w;
	assign tx_start_w = tx_st_r == ucp_pkg::UCP_IDLE && link.tx_cell_space_available &&
		link.tx_phy_select == tgt_addr_i && tx_valid_i && tx_first_i;
	assign tx_ready_o = tick_w && (tx_start_w || (tx_st_r == ucp_pkg::UCP_CELL && tx_valid_i));

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			tx_st_r <= ucp_pkg::UCP_IDLE;
			tx_cnt_r <= 6'h00;
			link.tx_phy_select <= `UCP_ADDR_RST;
			link.tx_cell_enable_n <= 1'b1;
			link.tx_cell_start_marker <= 1'b0;
			link.tx_cell_word_bus <= `UCP_WORD_RST;
			link.tx_cell_parity_bit <= 1'b0;
		end
		else if (tick_w)
		begin
			link.tx_phy_select <= tgt_addr_i;
			link.tx_cell_enable_n <= !tx_ready_o;
			link.tx_cell_start_marker <= tx_start_w;
			if (tx_ready_o)
			begin
				link.tx_cell_word_bus <= ucp_pkg::ucp_mask(tx_word_i, bus16_i);
				link.tx_cell_parity_bit <= ucp_pkg::ucp_par(tx_word_i, bus16_i, odd_par_i);
				tx_cnt_r <= tx_start_w ? 6'h00 : tx_cnt_r + 6'h01;
				if (tx_start_w)
					tx_st_r <= ucp_pkg::UCP_CELL;
				else if (tx_cnt_r == last_w - 6'h01)
					tx_st_r <= ucp_pkg::UCP_IDLE;
			end
		end
	end

	// Receive: poll, enable for a whole cell, sample a cycle later
	ucp_pkg::ucp_cell_st_t rx_st_r;
	logic [5:0] iss_r;
	logic pend_w;
	// Word launched at the last rise stands until the next rise
	assign pend_w = !link.rx_cell_enable_n;
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			rx_st_r <= ucp_pkg::UCP_IDLE;
			iss_r <= 6'h00;
			link.rx_phy_select <= `UCP_ADDR_RST;
			link.rx_cell_enable_n <= 1'b1;
		end
		else if (tick_w)
		begin
			link.rx_phy_select <= tgt_addr_i;
			if (rx_st_r == ucp_pkg::UCP_IDLE)
			begin
				// Enable falls from high only after a poll cycle
				if (link.rx_cell_ready_available && rx_accept_i &&
					link.rx_phy_select == tgt_addr_i && link.rx_cell_enable_n)
				begin
					rx_st_r <= ucp_pkg::UCP_CELL;
					link.rx_cell_enable_n <= 1'b0;
					iss_r <= 6'h00;
				end
			end
			else if (iss_r == last_w)
			begin
				rx_st_r <= ucp_pkg::UCP_IDLE;
				link.rx_cell_enable_n <= 1'b1;
			end
			else
				iss_r <= iss_r + 6'h01;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			rx_word_o <= `UCP_WORD_RST;
			rx_first_o <= 1'b0;
			rx_par_err_o <= 1'b0;
			rx_valid_o <= 1'b0;
		end
		else
		begin
			rx_valid_o <= tick_w && pend_w;
			if (tick_w && pend_w)
			begin
				rx_word_o <= link.rx_cell_word_bus;
				rx_first_o <= link.rx_cell_start_marker;
				rx_par_err_o <= link.rx_cell_parity_bit !=
					ucp_pkg::ucp_par(link.rx_cell_word_bus, bus16_i, odd_par_i);
			end
		end
	end
endmodule

//--- ucp_link_chk.sv
// Checker of the link wires between the two cell port ends
`timescale 1ns/10ps
`include "ucp_regs.svh"
module ucp_link_chk (
	input wire logic rst_i,
	input wire logic bus16_i,
	input wire logic odd_par_i,
	input wire logic [4:0] port_addr_i,
	input wire logic tx_cell_clock,
	input wire logic [15:0] tx_cell_word_bus,
	input wire logic tx_cell_parity_bit,
	input wire logic tx_cell_start_marker,
	input wire logic tx_cell_enable_n,
	input wire logic [4:0] tx_phy_select,
	input wire logic tx_cell_space_available_oe,
	input wire logic rx_cell_clock,
	input wire logic rx_cell_enable_n,
	input wire logic [4:0] rx_phy_select,
	input wire logic [15:0] rx_cell_word_bus,
	input wire logic rx_cell_parity_bit,
	input wire logic rx_cell_start_marker,
	input wire logic rx_cell_bus_oe,
	input wire logic rx_cell_ready_available,
	input wire logic rx_cell_ready_available_oe
);
	logic [5:0] cnt_r;

	// Words of the current transmit cell after its marker
	always_ff @(posedge tx_cell_clock)
	begin
		if (rst_i)
			cnt_r <= 6'h00;
		else if (!tx_cell_enable_n)
		begin
			if (tx_cell_start_marker)
				cnt_r <= 6'h01;
			else if (cnt_r != 6'h00)
				cnt_r <= (cnt_r == (bus16_i ? `UCP_LAST16 : `UCP_LAST8)) ? 6'h00 : cnt_r + 6'h01;
		end
	end

	sequence rx_start;
		$fell(rx_cell_enable_n) && rx_cell_ready_available;
	endsequence

	sequence rx_marker_once;
		rx_cell_start_marker ##1 !rx_cell_start_marker [*8];
	endsequence

	chk_rx_oe_follow: assert property (@(posedge rx_cell_clock) disable iff (rst_i)
		rx_cell_bus_oe |-> !$past(rx_cell_enable_n)) else $error("rx bus driven without enable");
	chk_rx_par_sense: assert property (@(posedge rx_cell_clock) disable iff (rst_i)
		rx_cell_bus_oe |-> rx_cell_parity_bit == ((^(bus16_i ? rx_cell_word_bus
		: {8'h00, rx_cell_word_bus[7:0]})) ^ odd_par_i)) else $error("rx parity wrong");
	chk_rx_first_word: assert property (@(posedge rx_cell_clock) disable iff (rst_i)
		rx_start |=> rx_marker_once) else $error("rx start marker misplaced");
	chk_rx_clav_sel: assert property (@(posedge rx_cell_clock) disable iff (rst_i)
		rx_cell_ready_available_oe == (rx_phy_select == port_addr_i)) else $error("rx clav drive");
	chk_tx_clav_sel: assert property (@(posedge tx_cell_clock) disable iff (rst_i)
		tx_cell_space_available_oe == (tx_phy_select == port_addr_i)) else $error("tx clav drive");
	chk_tx_par_width: assert property (@(posedge tx_cell_clock) disable iff (rst_i)
		!tx_cell_enable_n |-> tx_cell_parity_bit == ((^(bus16_i ? tx_cell_word_bus
		: {8'h00, tx_cell_word_bus[7:0]})) ^ odd_par_i)) else $error("tx parity wrong");
	chk_tx_byte_lane: assert property (@(posedge tx_cell_clock) disable iff (rst_i)
		!tx_cell_enable_n && !bus16_i |-> tx_cell_word_bus[15:8] == 8'h00)
		else $error("tx upper byte used");
	chk_tx_whole_cell: assert property (@(posedge tx_cell_clock) disable iff (rst_i)
		tx_cell_start_marker && !tx_cell_enable_n |-> cnt_r == 6'h00)
		else $error("tx cell cut short");
	chk_tx_no_stray: assert property (@(posedge tx_cell_clock) disable iff (rst_i)
		!tx_cell_enable_n && !tx_cell_start_marker |-> cnt_r != 6'h00)
		else $error("tx enable outside cell");
endmodule

//--- tb_top.sv
// Testbench joining both cell port ends
`timescale 1ns/10ps
module tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic bus16 = 1'b0;
	logic odd_par = 1'b0;
	logic [4:0] port_addr = 5'h03;
	logic tx_sink_ready = 1'b1;
	logic rx_accept = 1'b1;
	logic [15:0] tx_word = 16'h0000;
	logic tx_first = 1'b0;
	logic tx_valid = 1'b0;
	logic [15:0] rx_word = 16'h0000;
	logic rx_valid = 1'b0;
	logic [15:0] p_tx_word;
	logic [15:0] a_rx_word;
	logic p_tx_first, p_tx_par_err, p_tx_valid, p_rx_ready;
	logic a_tx_ready, a_rx_first, a_rx_par_err, a_rx_valid;
	logic [17:0] tx_q[$];
	logic [17:0] rx_q[$];
	int seed = 90;
	int n_mismatch = 0;
	int checked = 0;

	ucp_link_if link();

	always #12.5 clk_sys_i = ~clk_sys_i;

	ucp_phy_end i_ucp_phy_end (.link(link), .clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.bus16_i(bus16), .odd_par_i(odd_par), .port_addr_i(port_addr),
		.tx_sink_ready_i(tx_sink_ready), .tx_word_o(p_tx_word), .tx_first_o(p_tx_first),
		.tx_par_err_o(p_tx_par_err), .tx_valid_o(p_tx_valid), .rx_word_i(rx_word),
		.rx_valid_i(rx_valid), .rx_ready_o(p_rx_ready));
	ucp_atm_end i_ucp_atm_end (.link(link), .clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.bus16_i(bus16), .odd_par_i(odd_par), .tgt_addr_i(port_addr), .tx_word_i(tx_word),
		.tx_first_i(tx_first), .tx_valid_i(tx_valid), .tx_ready_o(a_tx_ready),
		.rx_accept_i(rx_accept), .rx_word_o(a_rx_word), .rx_first_o(a_rx_first),
		.rx_par_err_o(a_rx_par_err), .rx_valid_o(a_rx_valid));
	ucp_link_chk i_ucp_link_chk (.rst_i(rst_i), .bus16_i(bus16), .odd_par_i(odd_par),
		.port_addr_i(port_addr), .tx_cell_clock(link.tx_cell_clock),
		.tx_cell_word_bus(link.tx_cell_word_bus), .tx_cell_parity_bit(link.tx_cell_parity_bit),
		.tx_cell_start_marker(link.tx_cell_start_marker),
		.tx_cell_enable_n(link.tx_cell_enable_n), .tx_phy_select(link.tx_phy_select),
		.tx_cell_space_available_oe(link.tx_cell_space_available_oe),
		.rx_cell_clock(link.rx_cell_clock), .rx_cell_enable_n(link.rx_cell_enable_n),
		.rx_phy_select(link.rx_phy_select), .rx_cell_word_bus(link.rx_cell_word_bus),
		.rx_cell_parity_bit(link.rx_cell_parity_bit),
		.rx_cell_start_marker(link.rx_cell_start_marker), .rx_cell_bus_oe(link.rx_cell_bus_oe),
		.rx_cell_ready_available(link.rx_cell_ready_available),
		.rx_cell_ready_available_oe(link.rx_cell_ready_available_oe));

	task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic timeout(input string what);
		n_mismatch++;
		$display("Error %s wait ran out", what);
		stop_test();
	endtask

	function automatic logic [15:0] rnd_word();
		logic [15:0] w;
		w = $random(seed);
		return bus16 ? w : {8'h00, w[7:0]};
	endfunction

	// Compare every delivered word with the model queues
	always @(negedge clk_sys_i)
	begin
		if (!rst_i && p_tx_valid === 1'b1)
		begin
			if (tx_q.size() == 0)
				check("tx stray", {p_tx_par_err, p_tx_first, p_tx_word}, 18'h3FFFF);
			else
				check("tx word", {p_tx_par_err, p_tx_first, p_tx_word}, tx_q.pop_front());
		end
		if (!rst_i && a_rx_valid === 1'b1)
		begin
			if (rx_q.size() == 0)
				check("rx stray", {a_rx_par_err, a_rx_first, a_rx_word}, 18'h3FFFF);
			else
				check("rx word", {a_rx_par_err, a_rx_first, a_rx_word}, rx_q.pop_front());
		end
	end

	task automatic send_cell();
		logic [15:0] w;
		int k;
		for (int i = 0; i < (bus16 ? 27 : 53); i++)
		begin
			w = rnd_word();
			tx_valid <= 1'b1;
			tx_first <= (i == 0);
			tx_word <= w;
			k = 0;
			do
			begin
				@(negedge clk_sys_i);
				k++;
			end
			while (a_tx_ready !== 1'b1 && k < 400);
			if (k >= 400)
				timeout("tx ready");
			tx_q.push_back({1'b0, i == 0, w});
			@(posedge clk_sys_i);
		end
	endtask

	task automatic load_cell();
		logic [15:0] w;
		int k;
		k = 0;
		do
		begin
			@(negedge clk_sys_i);
			k++;
		end
		while (p_rx_ready !== 1'b1 && k < 3000);
		if (k >= 3000)
			timeout("rx ready");
		@(posedge clk_sys_i);
		for (int i = 0; i < (bus16 ? 27 : 53); i++)
		begin
			w = rnd_word();
			rx_valid <= 1'b1;
			rx_word <= w;
			rx_q.push_back({1'b0, i == 0, w});
			@(posedge clk_sys_i);
		end
		rx_valid <= 1'b0;
		@(negedge clk_sys_i);
		check("rx ready", {17'h00000, p_rx_ready}, 18'h00000);
	endtask

	initial
	begin
		repeat (5) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		for (int m = 0; m < 4; m++)
		begin
			if (m > 0)
			begin
				rst_i <= 1'b1;
				bus16 <= m[1];
				odd_par <= m[0];
				port_addr <= 5'(3 + 9 * m);
				repeat (16) @(posedge clk_sys_i);
				rst_i <= 1'b0;
			end
			fork
				begin
					repeat (2) send_cell();
					tx_valid <= 1'b0;
				end
				repeat (2) load_cell();
			join
			for (int k = 0; (tx_q.size() + rx_q.size()) != 0; k++)
			begin
				if (k >= 4000)
					timeout("drain");
				@(posedge clk_sys_i);
			end
			repeat (40) @(posedge clk_sys_i);
		end
		stop_test();
	end
endmodule
